// *** src/cirs_pkg.sv ***
// Package for the exception sequencer: constants, states and carriers
package cirs_pkg;
   // Condition flag bit positions
   localparam int FLAG_OVF       = 7;
   localparam int FLAG_HALF      = 4;
   localparam int FLAG_MASK      = 3;
   localparam int FLAG_NEG       = 2;
   localparam int FLAG_ZERO      = 1;
   localparam int FLAG_CARRY     = 0;
   localparam logic [7:0] FLAGS_RESET   = 8'h68; // Mask set, unused bits high
   localparam logic [7:0] FLAGS_FIXED   = 8'h60; // Bits 6:5 always read one
   // Vectors and opcodes
   localparam logic [15:0] RESET_VEC_HI = 16'hfffe;
   localparam logic [15:0] RESET_VEC_LO = 16'hffff;
   localparam logic [7:0]  OP_RET_INT   = 8'h80;
   localparam logic [7:0]  OP_MASK_SET  = 8'h9b;
   localparam logic [7:0]  OP_HALT      = 8'h8e;
   localparam int          QUEUE_BYTES  = 3;
   localparam logic [1:0]  QUEUE_LAST   = 2'h2;
   localparam logic [15:0] SP_RESET     = 16'h00ff;
   localparam int          NUM_IRQ      = 8;
   localparam logic [15:0] IRQ_VEC_TOP  = 16'hfffc; // Source 0 highest
   // Register map
   localparam logic [7:0] REG_FLAGS   = 8'h00;
   localparam logic [7:0] REG_STATUS  = 8'h04;
   localparam logic [7:0] REG_SPTR    = 8'h08;
   localparam logic [7:0] REG_RETADDR = 8'h0c;
   localparam logic [7:0] REG_VECTOR  = 8'h10;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Sequencer states, one-hot
   typedef enum logic [9:0] {
      ST_RESET = 10'h001,
      ST_RVEC  = 10'h002,
      ST_RUN   = 10'h004,
      ST_STACK = 10'h008,
      ST_VECHI = 10'h010,
      ST_VECLO = 10'h020,
      ST_FREE  = 10'h040,
      ST_FILL  = 10'h080,
      ST_PULL  = 10'h100,
      ST_HALT  = 10'h200
   } cirs_state_t;

   // Memory bus request toward program memory
   typedef struct packed {
      logic        req;
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } cirs_mem_t;

   // Core registers as stacked
   typedef struct packed {
      logic [15:0] ret_addr;
      logic [7:0]  index_low;
      logic [7:0]  accum;
   } cirs_core_t;

   // Flag result report from the datapath
   typedef struct packed {
      logic       valid;
      logic [7:0] result;
      logic       is_add;
      logic       is_sub;
      logic       carry_out;
      logic       half_carry;
      logic       overflow;
      logic       shift_op;
      logic       wide;
      logic [15:0] wide_val;
   } cirs_alu_t;
endpackage

// *** src/cirs_sequencer.sv ***
// Exception and reset sequencer with condition flags and register slave
// Contract
// - Entry pushes return low, return high, index low, accumulator, flags.
// - Mask bit 3 set after stacking, before first service instruction.
// - Then vector high, vector low, one free cycle, three queue fetches.
// - Pending request waits for the current instruction to finish.
// - Vector chosen by highest priority request pending at entry start.
// - Stack pointer addresses next free byte, ends one below flags.
// - Stacked return address is the next main program instruction.
// - Return opcode 80, 9 cycles, pre-increment pulls, then refill queue.
// - Upper index byte is neither stacked nor restored.
// - No recognition at boundary right after mask-clear or flags transfer.
// - Mask set ignores maskable requests; clearing re-enables them.
// - Several pending at mask clear: highest priority served first.
// - Reset abandons activity immediately, no boundary wait.
// - Reset from power-on, watchdog, or external low pin.
// - After reset release, six cycles fetch vector at fffe/ffff and fill queue.
// - Bit 7 set on two's complement overflow, else cleared.
// - Bit 4 records carry from bit 3 into 4 on additions.
// - Bit 2 set when result or moved value has top bit set.
// - Bit 1 set when result or moved value is all zero.
// - Bit 0 carry out of bit 7 on add, borrow on subtract, shifts.
// - Mask-set opcode 9B sets the mask in a single cycle.
// - Halt opcode 8E clears the mask then stops until woken.
`timescale 1ns/1ns
`default_nettype none
module cirs_sequencer (
   // Clock and reset
   input  wire  logic                 MCLK_IN,
   input  wire  logic                 NRST_IN,
   // Reset sources
   input  wire  logic                 POR_IN,
   input  wire  logic                 WATCHDOG_RST_IN,
   input  wire  logic                 RST_PIN_N_IN,
   input  wire  logic                 SRC_BUSY_IN,
   // Interrupt requests and instruction boundary
   input  wire  logic [7:0]           IRQ_IN,
   input  wire  logic                 BOUNDARY_IN,
   input  wire  logic [7:0]           OPCODE_IN,
   input  wire  logic                 MASK_CLR_OP_IN,
   input  wire  logic                 FLAGS_XFER_IN,
   input  wire  logic [7:0]           FLAGS_XFER_VAL_IN,
   input  wire  logic                 WAKE_IN,
   input  wire  cirs_pkg::cirs_core_t CORE_IN,
   input  wire  cirs_pkg::cirs_alu_t  ALU_IN,
   // Program memory bus
   output cirs_pkg::cirs_mem_t        MEM_OUT,
   input  wire  logic [7:0]           MEM_RDATA_IN,
   // Core control outputs
   output logic                       CORE_HOLD_OUT,
   output cirs_pkg::cirs_core_t       CORE_LOAD_OUT,
   output logic                       CORE_LOAD_EN_OUT,
   output logic [15:0]                PC_OUT,
   output logic                       HALTED_OUT,
   output logic [7:0]                 FLAGS_OUT,
   // AXI4-Lite slave
   input  wire  logic [7:0]           S_AXI_AWADDR,
   input  wire  logic                 S_AXI_AWVALID,
   output logic                       S_AXI_AWREADY,
   input  wire  logic [31:0]          S_AXI_WDATA,
   input  wire  logic [3:0]           S_AXI_WSTRB,
   input  wire  logic                 S_AXI_WVALID,
   output logic                       S_AXI_WREADY,
   output logic [1:0]                 S_AXI_BRESP,
   output logic                       S_AXI_BVALID,
   input  wire  logic                 S_AXI_BREADY,
   input  wire  logic [7:0]           S_AXI_ARADDR,
   input  wire  logic                 S_AXI_ARVALID,
   output logic                       S_AXI_ARREADY,
   output logic [31:0]                S_AXI_RDATA,
   output logic [1:0]                 S_AXI_RRESP,
   output logic                       S_AXI_RVALID,
   input  wire  logic                 S_AXI_RREADY
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Highest priority pending source, lowest index wins
   function automatic logic [2:0] prio_pick(input logic [7:0] req);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = cirs_pkg::NUM_IRQ - 1; i >= 0; i--) begin
         if (req[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction

   // Vector high byte address for a source
   function automatic logic [15:0] vec_addr(input logic [2:0] idx);
      return cirs_pkg::IRQ_VEC_TOP - {12'h000, idx, 1'b0};
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   cirs_pkg::cirs_state_t state_q, state_d;
   logic [2:0]           step_q, step_d;
   logic [15:0]          sp_q, sp_d;
   logic [15:0]          pc_q, pc_d;
   logic [15:0]          vec_q, vec_d;
   logic [7:0]           flags_q, flags_d;
   logic [7:0]           frame_q[5];
   logic [7:0]           pull_q[5];
   logic [7:0]           pull_d;
   logic                 pull_we;
   logic                 inhibit_q, inhibit_d;
   logic                 ret_op_q, ret_op_d;
   logic                 hold_q, hold_d;
   logic                 rst_event;
   logic [7:0]           pending;
   logic                 take_irq;
   logic                 sw_flags_we;
   logic [7:0]           sw_flags_val;
   logic                 sw_sp_we;
   logic [15:0]          sw_sp_val;
   cirs_pkg::cirs_mem_t  mem_d, mem_q;

   // Any reset source abandons work at once
   assign rst_event = POR_IN | WATCHDOG_RST_IN | ~RST_PIN_N_IN;
   assign pending   = IRQ_IN & {8{~flags_q[cirs_pkg::FLAG_MASK]}};
   assign take_irq  = BOUNDARY_IN && (|pending) && !inhibit_q;

   // ------------------------------------------------------------
   // Sequencer next state
   // ------------------------------------------------------------
   always_comb begin
      logic [7:0] f;
      f         = flags_q;
      state_d   = state_q;
      step_d    = step_q;
      sp_d      = sw_sp_we ? sw_sp_val : sp_q;
      pc_d      = pc_q;
      vec_d     = vec_q;
      inhibit_d = inhibit_q;
      ret_op_d  = ret_op_q;
      hold_d    = 1'b1;
      mem_d     = '0;
      pull_d    = 8'h00;
      pull_we   = 1'b0;
      // Condition flag updates from the datapath
      if (ALU_IN.valid) begin
         f[cirs_pkg::FLAG_NEG]  = ALU_IN.wide ? ALU_IN.wide_val[15]
                                              : ALU_IN.result[7];
         f[cirs_pkg::FLAG_ZERO] = ALU_IN.wide ? (ALU_IN.wide_val == 16'h0000)
                                              : (ALU_IN.result == 8'h00);
         f[cirs_pkg::FLAG_OVF] = ALU_IN.overflow;
         if (ALU_IN.is_add) begin
            f[cirs_pkg::FLAG_HALF] = ALU_IN.half_carry;
         end
         if (ALU_IN.is_add || ALU_IN.is_sub || ALU_IN.shift_op) begin
            f[cirs_pkg::FLAG_CARRY] = ALU_IN.carry_out;
         end
      end
      if (sw_flags_we) begin
         f = sw_flags_val;
      end
      unique case (state_q)
         cirs_pkg::ST_RESET: begin
            step_d = 3'h0;
            if (!SRC_BUSY_IN) begin
               state_d = cirs_pkg::ST_RVEC;
            end
         end
         cirs_pkg::ST_RVEC: begin
            // Six cycles: two vector bytes, then fill
            mem_d.req = 1'b1;
            unique case (step_q)
               3'h0: mem_d.addr = cirs_pkg::RESET_VEC_HI;
               3'h1: begin
                  mem_d.addr = cirs_pkg::RESET_VEC_LO;
                  pc_d[15:8] = MEM_RDATA_IN;
               end
               3'h2: begin
                  mem_d.req = 1'b0; // Free cycle, no stray read
                  pc_d[7:0] = MEM_RDATA_IN;
               end
               default: mem_d.addr = pc_q + 16'(step_q - 3'h3);
            endcase
            step_d = step_q + 3'h1;
            if (step_q == 3'h5) begin
               state_d = cirs_pkg::ST_RUN;
               step_d  = 3'h0;
            end
         end
         cirs_pkg::ST_RUN: begin
            hold_d = 1'b0;
            if (BOUNDARY_IN) begin
               inhibit_d = MASK_CLR_OP_IN || FLAGS_XFER_IN;
            end
            if (BOUNDARY_IN && FLAGS_XFER_IN) begin
               f = FLAGS_XFER_VAL_IN | cirs_pkg::FLAGS_FIXED;
            end
            if (BOUNDARY_IN && MASK_CLR_OP_IN) begin
               f[cirs_pkg::FLAG_MASK] = 1'b0;
            end
            if (take_irq) begin
               vec_d   = vec_addr(prio_pick(pending));
               pc_d    = CORE_IN.ret_addr;
               state_d = cirs_pkg::ST_STACK;
               step_d  = 3'h0;
               hold_d  = 1'b1;
            end else if (BOUNDARY_IN && OPCODE_IN == cirs_pkg::OP_MASK_SET) begin
               f[cirs_pkg::FLAG_MASK] = 1'b1;
            end else if (BOUNDARY_IN && OPCODE_IN == cirs_pkg::OP_HALT) begin
               f[cirs_pkg::FLAG_MASK] = 1'b0;
               state_d = cirs_pkg::ST_HALT;
            end else if (BOUNDARY_IN && OPCODE_IN == cirs_pkg::OP_RET_INT) begin
               state_d  = cirs_pkg::ST_PULL;
               step_d   = 3'h0;
               ret_op_d = 1'b1;
               hold_d   = 1'b1;
            end
         end
         cirs_pkg::ST_STACK: begin
            // Write frame byte at next free location
            mem_d.req   = 1'b1;
            mem_d.wr    = 1'b1;
            mem_d.addr  = sp_q;
            mem_d.wdata = frame_q[step_q];
            sp_d        = sp_q - 16'h0001;
            step_d      = step_q + 3'h1;
            if (step_q == 3'h4) begin
               f[cirs_pkg::FLAG_MASK] = 1'b1;
               state_d = cirs_pkg::ST_VECHI;
            end
         end
         cirs_pkg::ST_VECHI: begin
            mem_d.req  = 1'b1;
            mem_d.addr = vec_q;
            state_d    = cirs_pkg::ST_VECLO;
         end
         cirs_pkg::ST_VECLO: begin
            mem_d.req  = 1'b1;
            mem_d.addr = vec_q + 16'h0001;
            pc_d[15:8] = MEM_RDATA_IN;
            state_d    = cirs_pkg::ST_FREE;
         end
         cirs_pkg::ST_FREE: begin
            pc_d[7:0] = MEM_RDATA_IN;
            state_d   = cirs_pkg::ST_FILL;
            step_d    = 3'h0;
         end
         cirs_pkg::ST_FILL: begin
            mem_d.req  = 1'b1;
            mem_d.addr = pc_q + {14'h0000, step_q[1:0]};
            step_d     = step_q + 3'h1;
            if (step_q[1:0] == cirs_pkg::QUEUE_LAST) begin
               state_d  = cirs_pkg::ST_RUN;
               ret_op_d = 1'b0;
               step_d   = 3'h0;
            end
         end
         cirs_pkg::ST_PULL: begin
            // Pre-increment then read; data lands next cycle
            if (step_q != 3'h5) begin
               mem_d.req  = 1'b1;
               mem_d.addr = sp_q + 16'h0001;
               sp_d       = sp_q + 16'h0001;
            end
            if (step_q != 3'h0) begin
               pull_d  = MEM_RDATA_IN;
               pull_we = 1'b1;
            end
            if (step_q == 3'h1) begin
               f = MEM_RDATA_IN | cirs_pkg::FLAGS_FIXED;
            end
            if (step_q == 3'h4) begin
               pc_d[15:8] = MEM_RDATA_IN;
            end
            step_d = step_q + 3'h1;
            if (step_q == 3'h5) begin
               pc_d[7:0] = MEM_RDATA_IN;
               state_d   = cirs_pkg::ST_FILL;
               step_d    = 3'h0;
            end
         end
         cirs_pkg::ST_HALT: begin
            hold_d = 1'b1;
            if (WAKE_IN || (|pending)) begin
               state_d = cirs_pkg::ST_RUN;
            end
         end
         default: state_d = cirs_pkg::ST_RESET;
      endcase
      flags_d = f | cirs_pkg::FLAGS_FIXED;
   end

   // Sequencer registers; reset abandons everything at once
   always_ff @(posedge MCLK_IN) begin
      if (!NRST_IN || rst_event) begin
         state_q   <= cirs_pkg::ST_RESET;
         step_q    <= 3'h0;
         sp_q      <= cirs_pkg::SP_RESET;
         pc_q      <= 16'h0000;
         vec_q     <= 16'h0000;
         flags_q   <= cirs_pkg::FLAGS_RESET;
         inhibit_q <= 1'b0;
         ret_op_q  <= 1'b0;
         hold_q    <= 1'b1;
         mem_q     <= '0;
      end else begin
         state_q   <= state_d;
         step_q    <= step_d;
         sp_q      <= sp_d;
         pc_q      <= pc_d;
         vec_q     <= vec_d;
         flags_q   <= flags_d;
         inhibit_q <= inhibit_d;
         ret_op_q  <= ret_op_d;
         hold_q    <= hold_d;
         mem_q     <= mem_d;
      end
   end

   // Frame snapshot at entry, in push order
   always_ff @(posedge MCLK_IN) begin
      if (state_q == cirs_pkg::ST_RUN && take_irq) begin
         frame_q[0] <= CORE_IN.ret_addr[7:0];
         frame_q[1] <= CORE_IN.ret_addr[15:8];
         frame_q[2] <= CORE_IN.index_low;
         frame_q[3] <= CORE_IN.accum;
         frame_q[4] <= flags_q;
      end
      if (pull_we) begin
         pull_q[step_q - 3'h1] <= pull_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs toward the core
   // ------------------------------------------------------------
   assign MEM_OUT          = mem_q;
   assign CORE_HOLD_OUT    = hold_q;
   assign PC_OUT           = pc_q;
   assign FLAGS_OUT        = flags_q;
   assign HALTED_OUT       = (state_q == cirs_pkg::ST_HALT);
   assign CORE_LOAD_EN_OUT = ret_op_q && state_q == cirs_pkg::ST_FILL
                             && step_q == 3'h0;
   // Upper index byte is not part of the restore
   assign CORE_LOAD_OUT    = '{ret_addr: pc_q, index_low: pull_q[2],
                               accum: pull_q[1]};

   // ------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------
   logic       aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
   logic [7:0] awa_q, awa_d, ara_q, ara_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic       wr_go;

   assign wr_go        = aw_q && w_q && !b_q;
   assign sw_flags_we  = wr_go && awa_q == cirs_pkg::REG_FLAGS
                         && S_AXI_WSTRB != 4'h0;
   assign sw_flags_val = wd_q[7:0];
   assign sw_sp_we     = wr_go && awa_q == cirs_pkg::REG_SPTR;
   assign sw_sp_val    = wd_q[15:0];

   // Handshake and decode
   always_comb begin
      aw_d = aw_q;  w_d = w_q;  b_d = b_q;  r_d = r_q;
      awa_d = awa_q;  ara_d = ara_q;  wd_d = wd_q;  rd_d = rd_q;
      bresp_d = bresp_q;  rresp_d = rresp_q;
      if (S_AXI_AWVALID && !aw_q && !b_q) begin
         aw_d = 1'b1;  awa_d = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_q && !b_q) begin
         w_d = 1'b1;  wd_d = S_AXI_WDATA;
      end
      if (wr_go) begin
         aw_d = 1'b0;  w_d = 1'b0;  b_d = 1'b1;
         bresp_d = (awa_q == cirs_pkg::REG_FLAGS || awa_q == cirs_pkg::REG_SPTR)
                   ? cirs_pkg::RESP_OKAY : cirs_pkg::RESP_SLVERR;
      end
      if (b_q && S_AXI_BREADY) begin
         b_d = 1'b0;
      end
      if (S_AXI_ARVALID && !r_q) begin
         r_d = 1'b1;  rresp_d = cirs_pkg::RESP_OKAY;
         unique case (S_AXI_ARADDR)
            cirs_pkg::REG_FLAGS:   rd_d = {24'h000000, flags_q};
            cirs_pkg::REG_STATUS:  rd_d = {22'h000000, state_q};
            cirs_pkg::REG_SPTR:    rd_d = {16'h0000, sp_q};
            cirs_pkg::REG_RETADDR: rd_d = {16'h0000, pc_q};
            cirs_pkg::REG_VECTOR:  rd_d = {16'h0000, vec_q};
            default: begin
               rd_d = 32'h00000000;  rresp_d = cirs_pkg::RESP_SLVERR;
            end
         endcase
      end else if (r_q && S_AXI_RREADY) begin
         r_d = 1'b0;
      end
   end

   // Bus registers
   always_ff @(posedge MCLK_IN) begin
      if (!NRST_IN) begin
         aw_q <= 1'b0;  w_q <= 1'b0;  b_q <= 1'b0;  r_q <= 1'b0;
         awa_q <= 8'h00;  ara_q <= 8'h00;  wd_q <= 32'h0;  rd_q <= 32'h0;
         bresp_q <= cirs_pkg::RESP_OKAY;  rresp_q <= cirs_pkg::RESP_OKAY;
      end else begin
         aw_q <= aw_d;  w_q <= w_d;  b_q <= b_d;  r_q <= r_d;
         awa_q <= awa_d;  ara_q <= ara_d;  wd_q <= wd_d;  rd_q <= rd_d;
         bresp_q <= bresp_d;  rresp_q <= rresp_d;
      end
   end

   assign S_AXI_AWREADY = !aw_q && !b_q;
   assign S_AXI_WREADY  = !w_q && !b_q;
   assign S_AXI_BVALID  = b_q;
   assign S_AXI_BRESP   = bresp_q;
   assign S_AXI_ARREADY = !r_q;
   assign S_AXI_RVALID  = r_q;
   assign S_AXI_RDATA   = rd_q;
   assign S_AXI_RRESP   = rresp_q;
endmodule
`default_nettype wire

// *** testbench/cirs_checker.sv ***
// Port assertions for the exception sequencer
`timescale 1ns/1ns
`default_nettype none
module cirs_checker (
   // Clock and reset
   input wire logic                MCLK_IN,
   input wire logic                NRST_IN,
   // Observed inputs
   input wire logic                BOUNDARY_IN,
   input wire logic [7:0]          OPCODE_IN,
   input wire cirs_pkg::cirs_alu_t ALU_IN,
   // Observed outputs
   input wire cirs_pkg::cirs_mem_t MEM_OUT,
   input wire logic                CORE_HOLD_OUT,
   input wire logic                HALTED_OUT,
   input wire logic [7:0]          FLAGS_OUT
);
   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (!NRST_IN);
   // Write strobe on the memory bus
   logic wr_s;
   assign wr_s = MEM_OUT.req && MEM_OUT.wr;
   // Properties
   a_reset_idle: assert property (disable iff (1'b0) !NRST_IN |=>
      !MEM_OUT.req && CORE_HOLD_OUT && FLAGS_OUT == 8'h68) else $error("reset state");
   a_stack_frame: assert property ($rose(wr_s) |-> wr_s[*5] ##1 !wr_s)
      else $error("stack frame length");
   a_stack_desc: assert property (wr_s && $past(wr_s) |->
      MEM_OUT.addr == $past(MEM_OUT.addr) - 16'h1) else $error("stack address step");
   a_vector_seq: assert property ($fell(wr_s) |-> MEM_OUT.req && MEM_OUT.addr >= 16'hffee
      ##1 MEM_OUT.addr == $past(MEM_OUT.addr) + 16'h1 ##1 !MEM_OUT.req ##1 MEM_OUT.req[*3])
      else $error("vector fetch order");
   a_mask_entry: assert property ($fell(wr_s) |-> ##[0:3] FLAGS_OUT[3])
      else $error("mask not set on entry");
   a_mask_set: assert property (BOUNDARY_IN && OPCODE_IN == 8'h9b && !CORE_HOLD_OUT
      |=> FLAGS_OUT[3]) else $error("mask set opcode");
   a_halt_clear: assert property (BOUNDARY_IN && OPCODE_IN == 8'h8e && !CORE_HOLD_OUT
      |-> ##[1:2] (HALTED_OUT && !FLAGS_OUT[3])) else $error("halt opcode");
   a_ovf_flag: assert property (ALU_IN.valid |=> FLAGS_OUT[7] == $past(ALU_IN.overflow))
      else $error("overflow flag");
   a_zero_flag: assert property (ALU_IN.valid && !ALU_IN.wide |=>
      FLAGS_OUT[1] == ($past(ALU_IN.result) == 8'h00)) else $error("zero flag");
   // Main scenarios reached
   c_entry: cover property ($fell(wr_s));
   c_halt: cover property (HALTED_OUT);
   c_alu: cover property (ALU_IN.valid && ALU_IN.overflow);
endmodule
bind cirs_sequencer cirs_checker chk_u (.MCLK_IN, .NRST_IN, .BOUNDARY_IN, .OPCODE_IN,
   .ALU_IN, .MEM_OUT, .CORE_HOLD_OUT, .HALTED_OUT, .FLAGS_OUT);
`default_nettype wire

// *** testbench/cirs_mem_model.sv ***
// Program and stack memory on the far side of the bus
`timescale 1ns/1ns
`default_nettype none
module cirs_mem_model (
   // Clock and bus
   input  wire logic                clk_in,
   input  wire cirs_pkg::cirs_mem_t mem_in,
   output logic [7:0]               rdata_out
);
   logic [7:0] ram [256];
   logic [7:0] last_q;
   // Stack page writes
   always_ff @(posedge clk_in) begin
      if (mem_in.req && mem_in.wr) ram[mem_in.addr[7:0]] <= mem_in.wdata;
      last_q <= rdata_out;
   end
   // Read data, toggling junk when idle
   always_comb begin
      if (mem_in.req && !mem_in.wr) begin
         rdata_out = (mem_in.addr[15:8] == 8'h00) ? ram[mem_in.addr[7:0]] : mem_in.addr[7:0] ^ 8'ha5;
      end else begin
         rdata_out = ~last_q;
      end
   end
endmodule
`default_nettype wire

// *** testbench/cirs_sequencer_tb_top.sv ***
// Testbench for the exception sequencer
`timescale 1ns/1ns
`default_nettype none
module cirs_sequencer_tb_top;
   logic MCLK_IN = 0, NRST_IN = 0, POR_IN = 0, WATCHDOG_RST_IN = 0, RST_PIN_N_IN = 1;
   logic SRC_BUSY_IN = 1, BOUNDARY_IN = 0, MASK_CLR_OP_IN = 0, FLAGS_XFER_IN = 0, WAKE_IN = 0;
   logic [7:0] IRQ_IN = 0, OPCODE_IN = 0, FLAGS_XFER_VAL_IN = 0, MEM_RDATA_IN, FLAGS_OUT;
   cirs_pkg::cirs_core_t CORE_IN = '{16'h1234, 8'h56, 8'h78}, CORE_LOAD_OUT, ld;
   cirs_pkg::cirs_alu_t ALU_IN = '0;
   cirs_pkg::cirs_mem_t MEM_OUT;
   logic CORE_HOLD_OUT, CORE_LOAD_EN_OUT, HALTED_OUT;
   logic [15:0] PC_OUT;
   logic [7:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
   logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA;
   logic [3:0] S_AXI_WSTRB = 4'hf;
   logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0;
   logic S_AXI_RREADY = 0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
   logic S_AXI_RVALID;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
   logic [15:0] rq [$];
   logic [7:0] fr [5] = '{8'h34, 8'h12, 8'h56, 8'h78, 8'h60};
   logic [2:0] rs [3] = '{3'b101, 3'b011, 3'b000};
   int n_fail = 0, num_checks = 0;
   cirs_sequencer dut_u (.*);
   cirs_mem_model mem_u (.clk_in(MCLK_IN), .mem_in(MEM_OUT), .rdata_out(MEM_RDATA_IN));
   // Clock, read-address log and restored-register capture
   always #4 MCLK_IN = ~MCLK_IN;
   always @(posedge MCLK_IN) begin
      if (MEM_OUT.req && !MEM_OUT.wr) rq.push_back(MEM_OUT.addr);
      if (CORE_LOAD_EN_OUT) ld <= CORE_LOAD_OUT;
   end
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value at %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge MCLK_IN);
   endtask
   task automatic run;
      wt(2);
      while (CORE_HOLD_OUT !== 1'b0) @(posedge MCLK_IN);
   endtask
   task automatic bnd(input logic [7:0] op, input logic clr);
      @(posedge MCLK_IN);
      BOUNDARY_IN <= 1;
      OPCODE_IN <= op;
      MASK_CLR_OP_IN <= clr;
      @(posedge MCLK_IN);
      BOUNDARY_IN <= 0;
      MASK_CLR_OP_IN <= 0;
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 0;
      w = 0;
      @(posedge MCLK_IN);
      {S_AXI_AWADDR, S_AXI_WDATA, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= {a, d, 3'b111};
      while (!(aw && w)) begin
         @(posedge MCLK_IN);
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin aw = 1; S_AXI_AWVALID <= 0; end
         if (S_AXI_WVALID && S_AXI_WREADY) begin w = 1; S_AXI_WVALID <= 0; end
      end
      do @(posedge MCLK_IN); while (S_AXI_BVALID !== 1'b1);
      S_AXI_BREADY <= 0;
      chk(S_AXI_BRESP, 2'h0);
   endtask
   task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      @(posedge MCLK_IN);
      {S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} <= {a, 2'b11};
      do @(posedge MCLK_IN); while (S_AXI_ARREADY !== 1'b1);
      S_AXI_ARVALID <= 0;
      while (S_AXI_RVALID !== 1'b1) @(posedge MCLK_IN);
      S_AXI_RREADY <= 0;
      chk(S_AXI_RDATA, e);
      chk(S_AXI_RRESP, r);
   endtask
   task automatic alu(input cirs_pkg::cirs_alu_t v, input logic [7:0] e);
      @(posedge MCLK_IN);
      ALU_IN <= v;
      @(posedge MCLK_IN);
      ALU_IN <= '0;
      @(posedge MCLK_IN);
      chk(FLAGS_OUT, e);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Hang guard
   initial begin
      #80000;
      n_fail++;
      finish_test;
   end
   // Test sequence
   initial begin
      wt(16);
      NRST_IN <= 1;
      wt(4);
      SRC_BUSY_IN <= 0;
      run;
      chk(rq[0], 16'hfffe);
      chk(rq[1], 16'hffff);
      axr(8'h00, 32'h68, 2'h0);
      axr(8'h20, 32'h0, 2'h2);
      axw(8'h08, 32'hf0);
      axw(8'h00, 32'h60);
      $display("end test reset and registers");
      IRQ_IN <= 8'h0c;
      rq.delete();
      bnd(8'h00, 1'b0);
      IRQ_IN <= 8'h00;
      run;
      for (int i = 0; i < 5; i++) chk(mem_u.ram[8'hf0 - i], fr[i]);
      chk({rq[0], rq[2], 16'(rq.size())}, {16'hfff8, 16'h5d5c, 16'h5});
      axr(8'h08, 32'heb, 2'h0);
      chk(FLAGS_OUT[3], 1'b1);
      rq.delete();
      bnd(8'h80, 1'b0);
      run;
      chk({rq[0], rq[4], rq[5]}, {16'hec, 16'hf0, 16'h1234});
      chk(ld, {16'h1234, 8'h56, 8'h78});
      chk(PC_OUT, 16'h1234);
      chk(FLAGS_OUT, 8'h60);
      $display("end test entry and return");
      bnd(8'h9b, 1'b0);
      wt(1);
      chk(FLAGS_OUT[3], 1'b1);
      IRQ_IN <= 8'h81;
      rq.delete();
      bnd(8'h00, 1'b0);
      wt(3);
      chk(rq.size(), 0);
      bnd(8'h00, 1'b1);
      wt(3);
      chk({FLAGS_OUT[3], 16'(rq.size())}, 17'h0);
      bnd(8'h00, 1'b0);
      wt(3);
      chk(rq.size(), 0);
      bnd(8'h00, 1'b0);
      IRQ_IN <= 8'h00;
      run;
      chk(rq[0], 16'hfffc);
      $display("end test masking");
      bnd(8'h8e, 1'b0);
      wt(3);
      chk({HALTED_OUT, FLAGS_OUT[3]}, 2'b10);
      WAKE_IN <= 1;
      run;
      WAKE_IN <= 0;
      alu('{valid: 1, result: 8'h80, is_add: 1, carry_out: 1, half_carry: 1, overflow: 1,
         default: 0}, 8'hf5);
      alu('{valid: 1, result: 8'h00, is_sub: 1, default: 0}, 8'h72);
      FLAGS_XFER_VAL_IN <= 8'h08;
      FLAGS_XFER_IN <= 1;
      bnd(8'h00, 1'b0);
      FLAGS_XFER_IN <= 0;
      wt(1);
      chk(FLAGS_OUT, 8'h68);
      $display("end test halt and flags");
      for (int k = 0; k < 3; k++) begin
         @(posedge MCLK_IN);
         {POR_IN, WATCHDOG_RST_IN, RST_PIN_N_IN} <= rs[k];
         @(posedge MCLK_IN);
         {POR_IN, WATCHDOG_RST_IN, RST_PIN_N_IN} <= 3'b001;
         @(posedge MCLK_IN);
         chk({CORE_HOLD_OUT, FLAGS_OUT}, 9'h168);
         rq.delete();
         run;
         chk(rq[0], 16'hfffe);
      end
      $display("end test reset sources");
      finish_test;
   end
endmodule
`default_nettype wire
